// ---- asc_pkg.sv ----
// constants and types shared by the static memory host controller
package asc_pkg;

   // ---------------------------------------------------------------
   // memory geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W      = 18;   // word address width
   localparam int DATA_W      = 16;   // data word width
   localparam int LANE_W      = 8;    // one byte lane
   localparam int LANES       = 2;    // lower and upper lane
   localparam int LANE_LO     = 0;    // index of the lower lane
   localparam int LANE_HI     = 1;    // index of the upper lane

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;      // sys_clk period
   localparam int T_WP_NS       = 8;       // least write pulse width
   localparam int T_ACC_NS      = 12;      // longest access time
   localparam int T_HZ_NS       = 6;       // longest output turn-off
   localparam int T_REC_MS      = 5;       // recovery after retention
   localparam int NS_PER_MS     = 1000000; // unit conversion

   // least times round up to whole cycles, never below one
   localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HZ_CYC   = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REC_CYC  = (T_REC_MS * NS_PER_MS) / CLK_PERIOD_NS;

   // pin input synchroniser depth, latency to the agreed value
   localparam int SYNC_LAT = 4;

   localparam int CNT_W    = 20;           // holds REC_CYC
   localparam logic [CNT_W-1:0] CNT_ONE  = 20'h0_0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h0_0000;

   // ---------------------------------------------------------------
   // active and inactive pin levels
   // ---------------------------------------------------------------
   localparam logic PIN_OFF = 1'b1;        // strobe not asserted
   localparam logic PIN_ON  = 1'b0;        // strobe asserted

   // ---------------------------------------------------------------
   // sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,      // deselected, address may move
      ST_WR_SETUP,  // select, lanes, data out, write strobe high
      ST_WR_PULSE,  // write strobe low
      ST_WR_END,    // write strobe high, data held
      ST_RD,        // select and output enable low
      ST_TURN,      // bus turnaround after a read
      ST_RET,       // deselected for supply retention
      ST_RECOVER    // waiting out the recovery time
   } asc_state_t;

endpackage : asc_pkg

// ---- asc_pin_sync.sv ----
// three-stage synchroniser for pins that come from outside sys_clk
`timescale 1ns/10ps
module asc_pin_sync #(
   parameter int WIDTH = 1              // bits to synchronise
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin_in,     // raw pin level
   output logic      [WIDTH-1:0] pin_q       // agreed, stable level
);
   import asc_pkg::*;

   // ---------------------------------------------------------------
   // flip-flop chain
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] s1_reg;             // first stage, metastable
   logic [WIDTH-1:0] s2_reg;             // second stage
   logic [WIDTH-1:0] s3_reg;             // third stage
   logic [WIDTH-1:0] q_reg;              // last agreed value

   // the first stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once the second and third stage agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   assign pin_q = q_reg;

endmodule : asc_pin_sync

// ---- asc_ctrl.sv ----
// host controller driving an asynchronous 16-bit static memory
//
// Function
// R01 - memory holds 256k words, two byte lanes
// R02 - chip deselected means lanes high impedance
// R03 - selected, both strobes high: no transfer
// R04 - full word read with both lanes selected
// R05 - lower lane read drives only lower byte
// R06 - upper lane read drives only upper byte
// R07 - full word write with both lanes
// R08 - lower lane write keeps upper byte
// R09 - upper lane write keeps lower byte
// R10 - no lanes selected: nothing stored or driven
// R11 - write only while select, strobe, lane low
// R12 - write starts at last falling strobe
// R13 - write ends at first rising strobe
// R14 - late select keeps device outputs off
// R15 - address moves only with write strobe high
// R16 - host never drives while device outputs
// R17 - no clock at the memory, levels only
// R18 - deselect before and during supply retention
// R19 - wait 5 ms after supply returns
`timescale 1ns/10ps
module asc_ctrl
   import asc_pkg::*;
#(
   parameter int unsigned REC_CYCLES = asc_pkg::REC_CYC // recovery count
) (
   input  wire  logic                        sys_clk,
   input  wire  logic                        rst,
   // user request side
   input  wire  logic                        req_valid,
   output logic                              req_ready,
   input  wire  logic                        req_write,
   input  wire  logic [asc_pkg::ADDR_W-1:0]  req_addr,
   input  wire  logic [asc_pkg::DATA_W-1:0]  req_wdata,
   input  wire  logic [asc_pkg::LANES-1:0]   req_lane_en,
   output logic                              rsp_valid,
   output logic       [asc_pkg::DATA_W-1:0]  rsp_rdata,
   // supply retention handshake
   input  wire  logic                        ret_req,
   input  wire  logic                        supply_ok,
   output logic                              ret_safe,
   output logic                              recovering,
   // memory pins
   output logic                              mem_cs_n,
   output logic                              mem_oe_n,
   output logic                              mem_we_n,
   output logic                              low_lane_sel_n,
   output logic                              high_lane_sel_n,
   output logic       [asc_pkg::ADDR_W-1:0]  word_addr,
   output logic       [asc_pkg::DATA_W-1:0]  data_pins_out,
   output logic       [asc_pkg::LANES-1:0]   data_pins_oe,
   input  wire  logic [asc_pkg::DATA_W-1:0]  data_pins_in
);
   import asc_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   asc_state_t          state_reg;        // sequencer state
   asc_state_t          state_next;       // next sequencer state
   logic [CNT_W-1:0]    cnt_reg;          // cycles left in a phase
   logic [CNT_W-1:0]    cnt_next;         // next phase count
   logic                cnt_done;         // phase count exhausted
   logic                cs_n_reg;         // chip select pin
   logic                oe_n_reg;         // output enable pin
   logic                we_n_reg;         // write enable pin
   logic [LANES-1:0]    sel_n_reg;        // lane select pins
   logic [ADDR_W-1:0]   addr_reg;         // address pin latch
   logic [DATA_W-1:0]   wdata_reg;        // write data latch
   logic [LANES-1:0]    lane_reg;         // lanes of this access
   logic [LANES-1:0]    drive_reg;        // per-lane drive enable
   logic [DATA_W-1:0]   rdata_reg;        // captured read word
   logic                rsp_reg;          // read answer pulse
   logic                supply_q;         // synchronised supply flag
   logic [DATA_W-1:0]   pins_q;           // synchronised data pins
   logic                take;             // request accepted now

   localparam logic [CNT_W-1:0] WP_LOAD  = CNT_W'(WP_CYC);
   localparam logic [CNT_W-1:0] RD_LOAD  = CNT_W'(ACC_CYC + SYNC_LAT);
   localparam logic [CNT_W-1:0] HZ_LOAD  = CNT_W'(HZ_CYC);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // the supply monitor and the data pins are outside sys_clk
   asc_pin_sync #(.WIDTH(1)) u_sync_supply (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (supply_ok),
      .pin_q   (supply_q)
   );

   asc_pin_sync #(.WIDTH(DATA_W)) u_sync_data (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (data_pins_in),
      .pin_q   (pins_q)
   );

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   assign cnt_done = (cnt_reg <= CNT_ONE);
   // requests are held off while retention is asked for
   assign take     = (state_reg == ST_IDLE) && req_valid && !ret_req;

   // next state and phase count; every phase is a whole cycle count
   always_comb begin
      state_next = state_reg;
      cnt_next   = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - CNT_ONE;
      unique case (state_reg)
         ST_IDLE: begin
            if (ret_req) begin
               state_next = ST_RET;                              // R18
            end else if (req_valid) begin
               state_next = req_write ? ST_WR_SETUP : ST_RD;
               cnt_next   = req_write ? CNT_ONE : RD_LOAD;
            end
         end
         ST_WR_SETUP: begin
            // select and lanes settle before the strobe falls last
            state_next = ST_WR_PULSE;                            // R12
            cnt_next   = WP_LOAD;
         end
         ST_WR_PULSE: begin
            if (cnt_done) begin
               state_next = ST_WR_END;                           // R13
            end
         end
         ST_WR_END: begin
            state_next = ST_IDLE;
         end
         ST_RD: begin
            if (cnt_done) begin
               state_next = ST_TURN;
               cnt_next   = HZ_LOAD;
            end
         end
         ST_TURN: begin
            // device output must be off before we may drive again
            if (cnt_done) begin
               state_next = ST_IDLE;                             // R16
            end
         end
         ST_RET: begin
            // stay deselected until supply is back and release asked
            if (!ret_req && supply_q) begin
               state_next = ST_RECOVER;                          // R18
               cnt_next   = CNT_W'(REC_CYCLES);
            end
         end
         ST_RECOVER: begin
            if (!supply_q) begin
               state_next = ST_RET;                              // R19
            end else if (cnt_done) begin
               state_next = ST_IDLE;                             // R19
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= CNT_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ---------------------------------------------------------------
   // request latch
   // ---------------------------------------------------------------
   // address only moves in idle, where select and strobe are high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
         lane_reg  <= '0;
      end else if (take) begin
         addr_reg  <= req_addr;                                  // R15
         wdata_reg <= req_wdata;
         lane_reg  <= req_lane_en;                               // R10
      end
   end

   // ---------------------------------------------------------------
   // memory strobes
   // ---------------------------------------------------------------
   // all strobes come from flops so the pins never glitch
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_n_reg  <= PIN_OFF;
         oe_n_reg  <= PIN_OFF;
         we_n_reg  <= PIN_OFF;
         sel_n_reg <= {LANES{PIN_OFF}};
      end else begin
         unique case (state_next)
            ST_WR_SETUP, ST_WR_END: begin
               cs_n_reg  <= PIN_ON;
               oe_n_reg  <= PIN_OFF;                             // R16
               we_n_reg  <= PIN_OFF;                             // R13
               sel_n_reg <= ~lane_next_sel();
            end
            ST_WR_PULSE: begin
               cs_n_reg  <= PIN_ON;                              // R11 R17
               oe_n_reg  <= PIN_OFF;
               we_n_reg  <= PIN_ON;                              // R12
               sel_n_reg <= ~lane_reg;                           // R08
            end
            ST_RD: begin
               cs_n_reg  <= PIN_ON;                              // R04
               oe_n_reg  <= PIN_ON;
               we_n_reg  <= PIN_OFF;
               sel_n_reg <= ~lane_next_sel();                    // R05
            end
            default: begin
               // idle, turnaround, retention, recovery: chip deselected
               cs_n_reg  <= PIN_OFF;                             // R02
               oe_n_reg  <= PIN_OFF;                             // R03
               we_n_reg  <= PIN_OFF;
               sel_n_reg <= {LANES{PIN_OFF}};
            end
         endcase
      end
   end

   // lanes of the access being started or in progress
   function automatic logic [LANES-1:0] lane_next_sel();
      lane_next_sel = take ? req_lane_en : lane_reg;
   endfunction : lane_next_sel

   // ---------------------------------------------------------------
   // data drive, per lane
   // ---------------------------------------------------------------
   // only lanes being written are driven, and only in a write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         drive_reg <= '0;
      end else if (state_next == ST_WR_SETUP
                   || state_next == ST_WR_PULSE
                   || state_next == ST_WR_END) begin
         drive_reg <= lane_next_sel();                           // R09
      end else begin
         drive_reg <= '0;                                        // R16
      end
   end

   // ---------------------------------------------------------------
   // read capture
   // ---------------------------------------------------------------
   // sampled after access time plus synchroniser latency, so the
   // agreed value reflects a settled bus; unselected lanes read 0
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= '0;
         rsp_reg   <= 1'b0;
      end else begin
         rsp_reg <= 1'b0;
         if (state_reg == ST_RD && cnt_done) begin
            for (int l = 0; l < LANES; l++) begin
               rdata_reg[l*LANE_W +: LANE_W] <= lane_reg[l]
                  ? pins_q[l*LANE_W +: LANE_W] : '0;             // R06
            end
            rsp_reg <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign req_ready       = (state_reg == ST_IDLE) && !ret_req;
   assign rsp_valid       = rsp_reg;
   assign rsp_rdata       = rdata_reg;
   assign ret_safe        = (state_reg == ST_RET);               // R18
   assign recovering      = (state_reg == ST_RECOVER);
   assign mem_cs_n        = cs_n_reg;
   assign mem_oe_n        = oe_n_reg;
   assign mem_we_n        = we_n_reg;
   assign low_lane_sel_n  = sel_n_reg[LANE_LO];
   assign high_lane_sel_n = sel_n_reg[LANE_HI];
   assign word_addr       = addr_reg;                            // R01
   assign data_pins_out   = wdata_reg;                           // R07
   assign data_pins_oe    = drive_reg;

endmodule : asc_ctrl

// ---- asc_ctrl_asserts.sv ----
// pin and handshake assertions for the static memory host controller
`timescale 1ns/10ps
module asc_ctrl_asserts
   import asc_pkg::*;
#(
   parameter int unsigned REC_CYCLES = asc_pkg::REC_CYC // recovery count
) (
   input wire logic                       sys_clk,
   input wire logic                       rst,
   input wire logic                       req_valid,
   input wire logic                       req_ready,
   input wire logic                       req_write,
   input wire logic [asc_pkg::LANES-1:0]  req_lane_en,
   input wire logic                       rsp_valid,
   input wire logic                       ret_safe,
   input wire logic                       recovering,
   input wire logic                       mem_cs_n,
   input wire logic                       mem_oe_n,
   input wire logic                       mem_we_n,
   input wire logic                       low_lane_sel_n,
   input wire logic                       high_lane_sel_n,
   input wire logic [asc_pkg::ADDR_W-1:0] word_addr,
   input wire logic [asc_pkg::LANES-1:0]  data_pins_oe
);
   // ---------------------------------------------------------------
   // clocking and helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic        take;          // request accepted this edge
   logic [31:0] rec_cnt_reg;   // cycles spent recovering so far
   assign take = req_valid && req_ready;
   // recovery cycles so far; holds the total for one cycle after recovery, then zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rec_cnt_reg <= '0;
      end else begin
         rec_cnt_reg <= recovering ? rec_cnt_reg + 32'h0000_0001 : '0;
      end
   end
   // ---------------------------------------------------------------
   // pin walks, first pin cycle seen one edge after take
   // ---------------------------------------------------------------
   sequence wr_walk;
      (!mem_cs_n && mem_we_n) ##1 !mem_we_n ##1
      (mem_we_n && !mem_cs_n) ##1 mem_cs_n;
   endsequence
   sequence rd_walk;
      (!mem_cs_n && !mem_oe_n && mem_we_n) [*6] ##1 mem_cs_n;
   endsequence
   a_wr_walk: assert property (take && req_write |-> ##1 wr_walk)
      else $error("write strobe walk wrong");
   a_rd_walk: assert property (take && !req_write |-> ##1 rd_walk)
      else $error("read strobe walk wrong");
   a_rd_latency: assert property (take && !req_write |->
      ##1 !rsp_valid [*6] ##1 rsp_valid)
      else $error("read response at wrong edge");
   a_wr_no_rsp: assert property (take && req_write |-> ##1 !rsp_valid [*4])
      else $error("write produced a response");
   a_lane_map: assert property (take |-> ##2
      ({high_lane_sel_n, low_lane_sel_n} == ~$past(req_lane_en, 2)) &&
      (data_pins_oe == ($past(req_write, 2) ? $past(req_lane_en, 2) : 2'h0)))
      else $error("lanes do not follow request");
   a_addr_guard: assert property ($changed(word_addr) |->
      (mem_we_n || mem_cs_n) && $past(mem_we_n || mem_cs_n))
      else $error("address moved with write armed");
   a_no_bus_fight: assert property (!(!mem_cs_n && !mem_oe_n &&
      |(data_pins_oe & ~{high_lane_sel_n, low_lane_sel_n})))
      else $error("host drives while memory outputs");
   a_idle_deselect: assert property (req_ready |->
      mem_cs_n && data_pins_oe == 2'h0)
      else $error("idle but selected or driving");
   a_ret_deselect: assert property (ret_safe |->
      mem_cs_n && $past(mem_cs_n))
      else $error("retention flagged while selected");
   a_rec_idle: assert property (recovering |-> mem_cs_n && !req_ready)
      else $error("access during recovery");
   a_rec_length: assert property ($fell(recovering) && !ret_safe |->
      rec_cnt_reg >= REC_CYCLES)
      else $error("recovery ended early");
endmodule : asc_ctrl_asserts

bind asc_ctrl asc_ctrl_asserts #(.REC_CYCLES(REC_CYCLES))
   asc_ctrl_asserts_inst (
   .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
   .req_ready(req_ready), .req_write(req_write), .req_lane_en(req_lane_en),
   .rsp_valid(rsp_valid), .ret_safe(ret_safe), .recovering(recovering),
   .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
   .low_lane_sel_n(low_lane_sel_n), .high_lane_sel_n(high_lane_sel_n),
   .word_addr(word_addr), .data_pins_oe(data_pins_oe)
);

// ---- asc_sram_model.sv ----
// behavioural model of the clockless 16-bit static memory
`timescale 1ns/10ps
module asc_sram_model
   import asc_pkg::*;
(
   input  wire logic                       mem_cs_n,
   input  wire logic                       mem_oe_n,
   input  wire logic                       mem_we_n,
   input  wire logic                       low_lane_sel_n,
   input  wire logic                       high_lane_sel_n,
   input  wire logic [asc_pkg::ADDR_W-1:0] word_addr,
   input  wire logic [asc_pkg::DATA_W-1:0] data_pins,
   output logic      [asc_pkg::DATA_W-1:0] dev_rdata,
   output logic      [asc_pkg::LANES-1:0]  dev_drive
);
   logic [DATA_W-1:0] store [int];  // sparse 256k word array
   bit   [LANES-1:0]  wr_act;       // two-state: no edge at time zero
   logic [LANES-1:0]  sel_n;        // lane selects as a vector
   assign sel_n = {high_lane_sel_n, low_lane_sel_n};
   // write window per lane, levels only
   // drive needs write strobe high: late selects stay off
   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         wr_act[l] = !mem_cs_n && !mem_we_n && !sel_n[l];
         dev_drive[l] = !mem_cs_n && !mem_oe_n && mem_we_n && !sel_n[l];
      end
   end
   // unwritten words read junk: the inverted low address bits
   function automatic logic [DATA_W-1:0] look(input logic [ADDR_W-1:0] a);
      return store.exists(a) ? store[a] : ~a[DATA_W-1:0];
   endfunction : look
   // byte kept is the bus value as the window closes
   task automatic keep_lane(input int l);
      logic [DATA_W-1:0] w;
      w = look(word_addr);
      w[l*LANE_W +: LANE_W] = data_pins[l*LANE_W +: LANE_W];
      store[word_addr] = w;
   endtask : keep_lane
   always @(negedge wr_act[0]) keep_lane(LANE_LO);
   always @(negedge wr_act[1]) keep_lane(LANE_HI);
   // output garbles at once, settles one access time later
   always @(word_addr, mem_cs_n, mem_oe_n, sel_n) begin
      dev_rdata = ~dev_rdata;
      dev_rdata <= #(T_ACC_NS) look(word_addr);
   end
   initial dev_rdata = '0;
endmodule : asc_sram_model

// ---- asc_ctrl_test.sv ----
// self-checking bench for the static memory host controller
`timescale 1ns/10ps
module asc_ctrl_test;
   import asc_pkg::*;
   localparam int unsigned REC_SIM = 20;  // short recovery
   localparam int          LIMIT   = 20000; // cycle ceiling for a hang
   logic                sys_clk = 1'b0, rst = 1'b1;
   logic                req_valid = 1'b0, req_write = 1'b0;
   logic [ADDR_W-1:0]   req_addr = '0;
   logic [DATA_W-1:0]   req_wdata = '0, data_pins_in, flt = 16'h5a3c;
   logic [LANES-1:0]    req_lane_en = '0, data_pins_oe, dev_drive;
   logic                ret_req = 1'b0, supply_ok = 1'b1;
   logic                req_ready, rsp_valid, ret_safe, recovering;
   logic                mem_cs_n, mem_oe_n, mem_we_n, lo_n, hi_n;
   logic [ADDR_W-1:0]   word_addr, adr [6];
   logic [DATA_W-1:0]   rsp_rdata, data_pins_out, dev_rdata;
   logic [DATA_W-1:0]   ref_mem [int]; // reference memory
   logic [DATA_W-1:0]   exp_q [$];     // expected reads, oldest first
   int                  miscompares = 0, num_checks = 0, cycles = 0;
   int                  n, w;
   // ---------------------------------------------------------------
   // design, memory model, resolved data pins
   // ---------------------------------------------------------------
   asc_ctrl #(.REC_CYCLES(REC_SIM)) asc_ctrl_inst (.sys_clk(sys_clk),
      .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_lane_en(req_lane_en), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .ret_req(ret_req), .supply_ok(supply_ok),
      .ret_safe(ret_safe), .recovering(recovering), .mem_cs_n(mem_cs_n),
      .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .low_lane_sel_n(lo_n),
      .high_lane_sel_n(hi_n), .word_addr(word_addr),
      .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
      .data_pins_in(data_pins_in));
   asc_sram_model asc_sram_model_inst (.mem_cs_n(mem_cs_n),
      .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .low_lane_sel_n(lo_n),
      .high_lane_sel_n(hi_n), .word_addr(word_addr),
      .data_pins(data_pins_in), .dev_rdata(dev_rdata),
      .dev_drive(dev_drive));
   // undriven lanes float to a moving pattern
   always @(posedge sys_clk) flt <= {flt[14:0], ~flt[15]};
   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         data_pins_in[l*LANE_W +: LANE_W] = data_pins_oe[l] ?
            data_pins_out[l*LANE_W +: LANE_W] : dev_drive[l] ?
            dev_rdata[l*LANE_W +: LANE_W] : flt[l*LANE_W +: LANE_W];
      end
   end
   initial forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   // ---------------------------------------------------------------
   // compare, report, finish
   // ---------------------------------------------------------------
   task automatic check(input logic [DATA_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   // one request, held until taken; reads noted at take
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] l);
      logic [DATA_W-1:0] d, m, k;
      d = DATA_W'($urandom);
      k = {{LANE_W{l[1]}}, {LANE_W{l[0]}}};
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_lane_en = l;
      while (req_ready !== 1'b1) @(negedge sys_clk);
      if (wr) ref_mem[a] = (ref_mem[a] & ~k) | (d & k);
      m = ref_mem[a] & k;
      if (!wr) exp_q.push_back(m);
      @(posedge sys_clk);
      @(negedge sys_clk);
      req_valid = 1'b0;
   endtask : xfer
   // each response retires the oldest note
   always @(negedge sys_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check(rsp_rdata, ~rsp_rdata);
         else check(rsp_rdata, exp_q.pop_front());
      end
   end
   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         summarize();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h2acfc669));
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      foreach (adr[i]) adr[i] = ADDR_W'($urandom);
      adr[0] = '0;
      adr[1] = '1;
      // full words first, both address ends
      foreach (adr[i]) xfer(1'b1, adr[i], 2'h3);
      // every lane code written, then full and same-lane reads
      for (int c = 0; c < 4; c++) begin
         foreach (adr[i]) begin
            xfer(1'b1, adr[i], LANES'(c));
            xfer(1'b0, adr[i], 2'h3);
            xfer(1'b0, adr[i], LANES'(c));
         end
      end
      // deselect, lower supply, then recover
      ret_req = 1'b1;
      repeat (10) @(negedge sys_clk);
      check(16'(ret_safe), 16'h0001);
      check(16'(mem_cs_n), 16'h0001);
      check(16'(req_ready), 16'h0000);
      supply_ok = 1'b0;
      repeat (8) @(negedge sys_clk);
      ret_req = 1'b0;
      repeat (8) @(negedge sys_clk);
      check(16'(ret_safe), 16'h0001);
      supply_ok = 1'b1;
      n = 0;
      for (w = 0; w < 200 && req_ready !== 1'b1; w++) begin
         @(negedge sys_clk);
         n += (recovering === 1'b1);
      end
      check(16'(n >= REC_SIM), 16'h0001);
      foreach (adr[i]) xfer(1'b0, adr[i], 2'h3);
      repeat (20) @(negedge sys_clk);
      check(DATA_W'(exp_q.size()), 16'h0000);
      summarize();
   end
endmodule : asc_ctrl_test
